// ==== hw/hot_plug_pkg.sv ====
// hot_plug_pkg: constants shared by the hot plug slot controller and its SMBus host
// assumes both ends run from one 125 MHz system clock
package hot_plug_pkg;
  localparam int NSLOT = 2;
  localparam int CLK_PERIOD_NS = 8;
  // command byte values of the slot controller registers
  localparam logic [7:0] CMD_CTRL_A = 8'h02;
  localparam logic [7:0] CMD_CTRL_B = 8'h03;
  localparam logic [7:0] CMD_STAT_A = 8'h04;
  localparam logic [7:0] CMD_STAT_B = 8'h05;
  localparam logic [7:0] CMD_COMMON = 8'h06;
  localparam logic [7:0] CMD_LIMIT = 8'h07;
  // slot_control_reg fields
  localparam int CTL_AUX = 0;
  localparam int CTL_MAIN = 1;
  localparam int CTL_OVR_DIS = 2;
  localparam int CTL_MAIN_PG = 6;
  localparam int CTL_AUX_PG = 7;
  // slot status fields
  localparam int ST_F3V = 0;
  localparam int ST_F12V = 2;
  localparam int ST_FAUX = 4;
  localparam int ST_AUX_ON = 5;
  localparam int ST_MAIN_ON = 6;
  localparam int ST_FAULT = 7;
  // common status fields
  localparam int CS_UV = 1;
  localparam int CS_OT = 2;
  localparam int CS_MASK = 3;
  localparam int CS_GIN = 4;
  // serial link
  localparam logic [3:0] ADDR_PREFIX = 4'h8;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int SCL_QUARTER_CYC = SCL_PERIOD_NS / CLK_PERIOD_NS / 4;
  localparam int POWER_ON_DELAY_US = 250;
  localparam int POWER_ON_DELAY_CYC = POWER_ON_DELAY_US * 1000 / CLK_PERIOD_NS;
  // host controller registers on AHB-Lite
  localparam logic [31:0] HOST_CMD_ADDR = 32'h0000_0000;
  localparam logic [31:0] HOST_STAT_ADDR = 32'h0000_0004;
  localparam int HCMD_CMD_LSB = 0;
  localparam int HCMD_DATA_LSB = 8;
  localparam int HCMD_OP_LSB = 16;
  localparam int HCMD_ADDR_LSB = 24;
  localparam int HST_BUSY = 0;
  localparam int HST_NACK = 1;
  localparam int HST_RX_LSB = 8;
  typedef enum logic [1:0] {OP_NONE, OP_WRITE, OP_READ, OP_RECV} host_op_e;
endpackage : hot_plug_pkg

// ==== hw/hot_plug_slot_dev.sv ====
// hot_plug_slot_dev: control, fault and reporting logic of a dual-slot hot plug controller
// with an SMBus target; all pins and monitors it reads arrive asynchronously and are synchronised
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
module hot_plug_slot_dev (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // serial management port
  smbus_link_if.dev serialMgmtPort,
  // pin control port, per slot
  input wire logic [hot_plug_pkg::NSLOT-1:0] mainPowerRequest,
  input wire logic [hot_plug_pkg::NSLOT-1:0] auxPowerRequest,
  input wire logic [hot_plug_pkg::NSLOT-1:0] overrideN,
  // analogue monitors, per slot
  input wire logic [hot_plug_pkg::NSLOT-1:0] mainGood,
  input wire logic [hot_plug_pkg::NSLOT-1:0] auxGood,
  input wire logic [hot_plug_pkg::NSLOT-1:0] oc12Trip,
  input wire logic [hot_plug_pkg::NSLOT-1:0] oc3Trip,
  input wire logic [hot_plug_pkg::NSLOT-1:0] ocAuxTrip,
  input wire logic [hot_plug_pkg::NSLOT-1:0] slotHot,
  // shared monitors and straps
  input wire logic inputUv,
  input wire logic standbySupplyUv,
  input wire logic dieHot,
  input wire logic [1:0] generalInput,
  input wire logic addrStrapBit2,
  input wire logic addrStrapBit1,
  input wire logic addrStrapBit0,
  // supply switches
  output logic [hot_plug_pkg::NSLOT-1:0] main12vOut,
  output logic [hot_plug_pkg::NSLOT-1:0] main3v3Out,
  output logic [hot_plug_pkg::NSLOT-1:0] auxSupplyOut,
  // open-drain outputs
  input wire logic [hot_plug_pkg::NSLOT-1:0] slotPowerGoodNIn,
  output logic [hot_plug_pkg::NSLOT-1:0] slotPowerGoodNO,
  output logic [hot_plug_pkg::NSLOT-1:0] slotPowerGoodNOe,
  input wire logic [hot_plug_pkg::NSLOT-1:0] slotFaultNIn,
  output logic [hot_plug_pkg::NSLOT-1:0] slotFaultNO,
  output logic [hot_plug_pkg::NSLOT-1:0] slotFaultNOe,
  input wire logic attentionNIn,
  output logic attentionNO,
  output logic attentionNOe
);
  import hot_plug_pkg::*;

  localparam int SW = 9 * NSLOT + 10;
  // override inputs and bus lines idle high, so they leave reset high
  localparam logic [SW-1:0] SYNC_RST = {{NSLOT{1'b1}}, {(SW - NSLOT - 2){1'b0}}, 2'b11};
  typedef enum logic [2:0] {S_IDLE, S_ADDR, S_CMD, S_WDATA, S_RDATA, S_IGNORE} link_e;

  function automatic logic wrHit(input logic en, input logic [7:0] ptr, input logic [7:0] cmd);
    wrHit = en && (ptr == cmd);
  endfunction : wrHit

  logic [SW-1:0] syncA_r;
  logic [SW-1:0] syncB_r;
  logic [NSLOT-1:0] ovrN, mReqPin, aReqPin, mGood, aGood, f12, f3, fAux, fHot;
  logic uvIn, uvStby, hotDie, sclS, sdaS;
  logic [1:0] gIn;
  logic [2:0] strap;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncA_r <= SYNC_RST;
      syncB_r <= SYNC_RST;
    end else begin
      syncA_r <= {overrideN, mainPowerRequest, auxPowerRequest, mainGood, auxGood, oc12Trip,
        oc3Trip, ocAuxTrip, slotHot, inputUv, standbySupplyUv, dieHot, generalInput,
        addrStrapBit2, addrStrapBit1, addrStrapBit0, serialMgmtPort.scl, serialMgmtPort.sda};
      syncB_r <= syncA_r;
    end
  end
  assign {ovrN, mReqPin, aReqPin, mGood, aGood, f12, f3, fAux, fHot, uvIn, uvStby, hotDie,
    gIn, strap, sclS, sdaS} = syncB_r;

  // address straps caught once after reset, later strap changes ignored
  // waits out both sync stages, else the chain's reset value would be caught
  logic [2:0] strapAddr_r;
  logic strapTaken_r;
  logic [1:0] strapWait_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      strapAddr_r <= '0;
      strapTaken_r <= 1'b0;
      strapWait_r <= '0;
    end else begin
      strapWait_r <= {strapWait_r[0], 1'b1};
      if (strapWait_r[1] && !strapTaken_r) begin
        strapAddr_r <= strap;
        strapTaken_r <= 1'b1;
      end
    end
  end
  wire logic [6:0] ownAddr = {ADDR_PREFIX, strapAddr_r};

  // link edges and bus conditions
  logic sclPrev_r, sdaPrev_r;
  wire logic sclRise = sclS & ~sclPrev_r;
  wire logic sclFall = ~sclS & sclPrev_r;
  wire logic startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  wire logic stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;

  link_e st_r;
  logic [3:0] bitCnt_r;
  logic [7:0] shift_r, tx_r, ptr_r;
  logic ackPh_r, sdaOe_r, wrEn_r;
  logic [7:0] rdByte;
  wire logic receiving = (st_r == S_ADDR) || (st_r == S_CMD) || (st_r == S_WDATA)
    || (st_r == S_RDATA);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclPrev_r <= 1'b1;
      sdaPrev_r <= 1'b1;
      st_r <= S_IDLE;
      bitCnt_r <= '0;
      shift_r <= '0;
      tx_r <= '0;
      ptr_r <= '0;
      ackPh_r <= 1'b0;
      sdaOe_r <= 1'b0;
      wrEn_r <= 1'b0;
    end else begin
      sclPrev_r <= sclS;
      sdaPrev_r <= sdaS;
      wrEn_r <= 1'b0;
      if (startCond) begin
        st_r <= S_ADDR;
        bitCnt_r <= '0;
        ackPh_r <= 1'b0;
        sdaOe_r <= 1'b0;
      end else if (stopCond) begin
        st_r <= S_IDLE;
        ackPh_r <= 1'b0;
        sdaOe_r <= 1'b0;
      end else if (sclRise && !ackPh_r && receiving) begin
        shift_r <= {shift_r[6:0], sdaS};
        bitCnt_r <= bitCnt_r + 4'h1;
      end else if (sclFall && ackPh_r) begin
        // acknowledge slot ends; a read then puts out its first bit
        ackPh_r <= 1'b0;
        bitCnt_r <= '0;
        sdaOe_r <= (st_r == S_RDATA) && !tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end else if (sclFall && bitCnt_r == BYTE_BITS) begin
        case (st_r)
          S_ADDR: begin
            if (shift_r[7:1] == ownAddr) begin
              sdaOe_r <= 1'b1;
              ackPh_r <= 1'b1;
              tx_r <= rdByte;
              st_r <= shift_r[0] ? S_RDATA : S_CMD;
            end else begin
              st_r <= S_IGNORE;
            end
          end
          S_CMD: begin
            ptr_r <= shift_r;
            sdaOe_r <= 1'b1;
            ackPh_r <= 1'b1;
            st_r <= S_WDATA;
          end
          S_WDATA: begin
            // one data byte per write; further bytes go unacknowledged
            wrEn_r <= 1'b1;
            sdaOe_r <= 1'b1;
            ackPh_r <= 1'b1;
            st_r <= S_IGNORE;
          end
          S_RDATA: begin
            sdaOe_r <= 1'b0;
            st_r <= S_IGNORE;
          end
          default: st_r <= S_IGNORE;
        endcase
      end else if (sclFall && st_r == S_RDATA) begin
        sdaOe_r <= !tx_r[7];
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end
  assign serialMgmtPort.devSdaO = 1'b0;
  assign serialMgmtPort.devSdaOe = sdaOe_r;

  // slot state
  logic [NSLOT-1:0][2:0] ctrl_r, ctrl_nxt, sticky_r, sticky_nxt;
  logic [NSLOT-1:0] mainTrip_r, mainTrip_nxt, auxTrip_r, auxTrip_nxt;
  logic [NSLOT-1:0] mainOn_r, mainOn_nxt, auxOn_r, auxOn_nxt;
  logic [NSLOT-1:0] pgOe_r, pgOe_nxt, faultOe_r, faultOe_nxt, faultRaw, slotEn;
  logic [NSLOT-1:0][7:0] ctrlRd, statRd;
  wire logic uvAny = uvIn | uvStby;

  for (genvar s = 0; s < NSLOT; s++) begin : g_slot
    wire logic [7:0] ctlCmd = CMD_CTRL_A + 8'(s);
    wire logic [7:0] statCmd = CMD_STAT_A + 8'(s);
    wire logic forceOn = ~ovrN[s] & ~ctrl_r[s][CTL_OVR_DIS];
    wire logic pinMode = mReqPin[s] | aReqPin[s];
    wire logic mainReq = mReqPin[s] | ctrl_r[s][CTL_MAIN];
    wire logic auxReq = aReqPin[s] | ctrl_r[s][CTL_AUX];
    // protections and input lockouts are bypassed under override
    wire logic slotCommon = ~forceOn & (fHot[s] | hotDie | uvAny);
    wire logic mainFault = mainReq & (slotCommon | ~forceOn & (f12[s] | f3[s]));
    wire logic auxFault = auxReq & (slotCommon | ~forceOn & fAux[s]);
    wire logic [2:0] setF = {3{slotEn[s] & ~forceOn}}
      & {fAux[s] | fHot[s] | hotDie | uvAny, f12[s] | slotCommon, f3[s] | slotCommon};
    wire logic [7:0] wrD = shift_r;
    assign slotEn[s] = |ctrl_r[s][1:0];
    assign mainTrip_nxt[s] = mainReq & (mainTrip_r[s] | mainFault);
    assign auxTrip_nxt[s] = auxReq & (auxTrip_r[s] | auxFault);
    // standby lockout still cuts everything, even under override
    assign mainOn_nxt[s] = ~uvStby & (forceOn | mainReq & ~mainTrip_nxt[s]);
    assign auxOn_nxt[s] = ~uvStby & (forceOn | auxReq & ~auxTrip_nxt[s]);
    assign pgOe_nxt[s] = ~forceOn & mainOn_r[s] & auxOn_r[s] & mGood[s] & aGood[s];
    assign faultRaw[s] = pinMode & (mainTrip_r[s] | auxTrip_r[s]);
    assign faultOe_nxt[s] = faultRaw[s] & ~forceOn;
    assign ctrl_nxt[s] = wrHit(wrEn_r, ptr_r, ctlCmd) ? wrD[2:0] : ctrl_r[s];
    assign sticky_nxt[s] = setF | sticky_r[s] & ~({3{wrHit(wrEn_r, ptr_r, statCmd)}}
      & {wrD[ST_FAUX], wrD[ST_F12V], wrD[ST_F3V]});
    always_comb begin
      ctrlRd[s] = '0;
      ctrlRd[s][2:0] = ctrl_r[s];
      ctrlRd[s][CTL_MAIN_PG] = mGood[s];
      ctrlRd[s][CTL_AUX_PG] = aGood[s];
      statRd[s] = '0;
      statRd[s][ST_F3V] = sticky_r[s][0];
      statRd[s][ST_F12V] = sticky_r[s][1];
      statRd[s][ST_FAUX] = sticky_r[s][2];
      statRd[s][ST_AUX_ON] = auxOn_r[s];
      statRd[s][ST_MAIN_ON] = mainOn_r[s];
      statRd[s][ST_FAULT] = faultRaw[s];
    end
  end

  // common status
  logic mask_r;
  logic [1:0] csF_r;
  wire logic csWr = wrHit(wrEn_r, ptr_r, CMD_COMMON);
  wire logic [1:0] csSet = {2{|slotEn}} & {hotDie, uvAny};
  wire logic [1:0] csNxt = csSet | csF_r & ~({2{csWr}} & shift_r[CS_OT:CS_UV]);
  wire logic maskNxt = csWr ? shift_r[CS_MASK] : mask_r;
  wire logic attnNxt = ~mask_r & (|sticky_r | |csF_r);
  logic [7:0] csRd;
  always_comb begin
    csRd = '0;
    csRd[CS_OT:CS_UV] = csF_r;
    csRd[CS_MASK] = mask_r;
    csRd[CS_GIN +: 2] = gIn;
  end
  // unknown and reserved command values read as zero
  assign rdByte = (ptr_r == CMD_CTRL_A) ? ctrlRd[0] : (ptr_r == CMD_CTRL_B) ? ctrlRd[1]
    : (ptr_r == CMD_STAT_A) ? statRd[0] : (ptr_r == CMD_STAT_B) ? statRd[1]
    : (ptr_r == CMD_COMMON) ? csRd : 8'h00;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= '0;
      sticky_r <= '0;
      mainTrip_r <= '0;
      auxTrip_r <= '0;
      mainOn_r <= '0;
      auxOn_r <= '0;
      pgOe_r <= '0;
      faultOe_r <= '0;
      mask_r <= 1'b0;
      csF_r <= '0;
      attentionNOe <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      sticky_r <= sticky_nxt;
      mainTrip_r <= mainTrip_nxt;
      auxTrip_r <= auxTrip_nxt;
      mainOn_r <= mainOn_nxt;
      auxOn_r <= auxOn_nxt;
      pgOe_r <= pgOe_nxt;
      faultOe_r <= faultOe_nxt;
      mask_r <= maskNxt;
      csF_r <= csNxt;
      attentionNOe <= attnNxt;
    end
  end
  assign main12vOut = mainOn_r;
  assign main3v3Out = mainOn_r;
  assign auxSupplyOut = auxOn_r;
  assign slotPowerGoodNO = '0;
  assign slotPowerGoodNOe = pgOe_r;
  assign slotFaultNO = '0;
  assign slotFaultNOe = faultOe_r;
  assign attentionNO = 1'b0;
endmodule : hot_plug_slot_dev

// ==== hw/smbus_host_ctrl.sv ====
// smbus_host_ctrl: AHB-Lite programmed SMBus host issuing byte write, byte read and receive
// assumes a single AHB-Lite master; the link clock is divided down from clk
module smbus_host_ctrl #(
  parameter int QUARTER_CYC = hot_plug_pkg::SCL_QUARTER_CYC
) (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // serial management port
  smbus_link_if.host serialMgmtPort
);
  import hot_plug_pkg::*;

  typedef enum logic [2:0] {K_START, K_AW, K_AR, K_CMD, K_DATA, K_RX, K_STOP} kind_e;

  function automatic kind_e stepKind(input host_op_e op, input logic [2:0] step);
    kind_e k;
    k = K_STOP;
    case (op)
      OP_WRITE: k = (step == 3'd0) ? K_START : (step == 3'd1) ? K_AW : (step == 3'd2) ? K_CMD
        : (step == 3'd3) ? K_DATA : K_STOP;
      OP_READ: k = (step == 3'd0 || step == 3'd3) ? K_START : (step == 3'd1) ? K_AW
        : (step == 3'd2) ? K_CMD : (step == 3'd4) ? K_AR : (step == 3'd5) ? K_RX
        : K_STOP;
      OP_RECV: k = (step == 3'd0) ? K_START : (step == 3'd1) ? K_AR : (step == 3'd2) ? K_RX
        : K_STOP;
      default: k = K_STOP;
    endcase
    return k;
  endfunction : stepKind

  // AHB address phase capture; zero wait states
  logic aWr_r, aCmd_r;
  logic [31:0] rd_r;
  logic busy_r, nack_r;
  logic [7:0] rx_r, cmd_r, data_r;
  logic [6:0] addr_r;
  host_op_e op_r;
  wire logic aTake = hsel & hready & htrans[1];
  wire logic [31:0] statWord = {16'h0000, rx_r, 6'h00, nack_r, busy_r};
  wire logic [31:0] rdNxt = (haddr == HOST_STAT_ADDR) ? statWord : 32'h0000_0000;
  wire logic cmdWr = aWr_r & aCmd_r;
  wire host_op_e newOp = host_op_e'(hwdata[HCMD_OP_LSB +: 2]);
  // command values above CMD_LIMIT and a busy engine refuse a new order
  wire logic cmdBad = hwdata[HCMD_CMD_LSB +: 8] > CMD_LIMIT;
  wire logic launch = cmdWr & ~busy_r & ~cmdBad & (newOp != OP_NONE);

  logic sdaA_r, sdaB_r;
  logic [15:0] div_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [2:0] step_r;
  logic sclOe_r, sdaOe_r;
  wire logic tick = busy_r && (div_r == 16'(QUARTER_CYC - 1));
  wire kind_e kind = nack_r ? K_STOP : stepKind(op_r, step_r);
  wire logic [7:0] txByte = (kind == K_AW) ? {addr_r, 1'b0} : (kind == K_AR) ? {addr_r, 1'b1}
    : (kind == K_CMD) ? cmd_r : data_r;
  wire logic isByte = (kind != K_START) && (kind != K_STOP);
  wire logic txBit = (kind != K_RX) && (bit_r != BYTE_BITS) && !txByte[3'd7 - bit_r[2:0]];
  // start: release, raise clock, pull data; stop: pull data, raise clock, release data
  wire logic sdaPh0 = (kind == K_STOP) ? 1'b1 : (kind == K_START) ? 1'b0 : txBit;
  wire logic sdaPh2 = (kind == K_START) ? 1'b1 : (kind == K_STOP) ? 1'b0 : sdaOe_r;
  wire logic ackMiss = isByte && (kind != K_RX) && (bit_r == BYTE_BITS) && sdaB_r;
  wire logic byteEnd = !isByte || (bit_r == BYTE_BITS);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aWr_r <= 1'b0;
      aCmd_r <= 1'b0;
      rd_r <= '0;
      sdaA_r <= 1'b1;
      sdaB_r <= 1'b1;
    end else begin
      aWr_r <= aTake & hwrite;
      aCmd_r <= haddr == HOST_CMD_ADDR;
      if (aTake && !hwrite) begin
        rd_r <= rdNxt;
      end
      sdaA_r <= serialMgmtPort.sda;
      sdaB_r <= sdaA_r;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      op_r <= OP_NONE;
      addr_r <= '0;
      cmd_r <= '0;
      data_r <= '0;
      rx_r <= '0;
      div_r <= '0;
      ph_r <= '0;
      bit_r <= '0;
      step_r <= '0;
      sclOe_r <= 1'b0;
      sdaOe_r <= 1'b0;
    end else if (launch) begin
      busy_r <= 1'b1;
      nack_r <= 1'b0;
      op_r <= newOp;
      addr_r <= hwdata[HCMD_ADDR_LSB +: 7];
      cmd_r <= hwdata[HCMD_CMD_LSB +: 8];
      data_r <= hwdata[HCMD_DATA_LSB +: 8];
      div_r <= '0;
      ph_r <= '0;
      bit_r <= '0;
      step_r <= '0;
    end else if (cmdWr && !busy_r && cmdBad) begin
      nack_r <= 1'b1;
    end else if (busy_r) begin
      div_r <= tick ? '0 : div_r + 16'h0001;
      if (tick) begin
        ph_r <= ph_r + 2'd1;
        case (ph_r)
          2'd0: sdaOe_r <= sdaPh0;
          2'd1: sclOe_r <= 1'b0;
          2'd2: begin
            sdaOe_r <= sdaPh2;
            if (kind == K_RX && bit_r != BYTE_BITS) begin
              rx_r <= {rx_r[6:0], sdaB_r};
            end
            if (ackMiss) begin
              nack_r <= 1'b1;
            end
          end
          default: begin
            sclOe_r <= (kind != K_STOP);
            bit_r <= byteEnd ? 4'h0 : bit_r + 4'h1;
            if (kind == K_STOP) begin
              busy_r <= 1'b0;
            end else if (byteEnd) begin
              step_r <= step_r + 3'd1;
            end
          end
        endcase
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_r;
  assign serialMgmtPort.hostSclO = 1'b0;
  assign serialMgmtPort.hostSclOe = sclOe_r;
  assign serialMgmtPort.hostSdaO = 1'b0;
  assign serialMgmtPort.hostSdaOe = sdaOe_r;
endmodule : smbus_host_ctrl

// ==== hw/smbus_link_if.sv ====
// smbus_link_if: the two-wire serial management link between host and slot controller
// assumes external pull-ups; a line is low while any end enables its low drive
interface smbus_link_if;
  logic hostSclO;
  logic hostSclOe;
  logic hostSdaO;
  logic hostSdaOe;
  logic devSdaO;
  logic devSdaOe;
  wire logic scl;
  wire logic sda;
  assign scl = ~(hostSclOe & ~hostSclO);
  assign sda = ~((hostSdaOe & ~hostSdaO) | (devSdaOe & ~devSdaO));
  modport dev (input scl, input sda, output devSdaO, output devSdaOe);
  modport host (input scl, input sda, output hostSclO, output hostSclOe, output hostSdaO,
    output hostSdaOe);
endinterface : smbus_link_if

// ==== tb/hot_plug_slot_mgmt_ctrl_chk.sv ====
// hot_plug_slot_mgmt_ctrl_chk: timing checks on the serial management wires
// assumes the host runs with QUARTER_CYC of 8, so each scl phase lasts 16 clocks
module hot_plug_slot_mgmt_ctrl_chk (
  // system
  input wire logic clk,
  input wire logic sys_rst,
  // link
  input wire logic hostSclOe,
  input wire logic hostSdaOe,
  input wire logic devSdaO,
  input wire logic devSdaOe,
  input wire logic scl,
  input wire logic sda
);
  logic [7:0] lowCnt_r;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence startSeq;
    $fell(sda) && scl && $past(scl);
  endsequence
  sequence stopSeq;
    $rose(sda) && scl && $past(scl);
  endsequence
  // saturates so a long scl low phase never wraps into the ack window
  always_ff @(posedge clk) begin
    if (sys_rst || scl) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hff) lowCnt_r <= lowCnt_r + 8'h01;
  end
  AST_RESET_IDLE: assert property ($fell(sys_rst) |-> !devSdaOe && !hostSclOe && !hostSdaOe)
    else $error("link not idle after reset");
  AST_DEV_CHANGE_SCL_LOW: assert property ($changed(devSdaOe) |-> !scl)
    else $error("target sda moved while scl high");
  AST_ACK_DELAY: assert property ($rose(devSdaOe) |-> lowCnt_r inside {[2:5]})
    else $error("target drive not 3 clocks after scl fall");
  AST_START_DEV_QUIET: assert property (startSeq |-> !devSdaOe)
    else $error("target driving at start");
  AST_STOP_RELEASE: assert property (stopSeq |-> (!devSdaOe) [*8])
    else $error("target drives after stop");
  AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
    else $error("scl high phase too short");
  AST_SCL_LOW_MIN: assert property ($fell(scl) |-> (!scl) [*8])
    else $error("scl low phase too short");
  AST_DEV_DRIVES_LOW: assert property (devSdaOe |-> !devSdaO && !sda)
    else $error("target drive does not pull sda low");
endmodule : hot_plug_slot_mgmt_ctrl_chk

// ==== tb/hot_plug_slot_mgmt_ctrl_tb.sv ====
// hot_plug_slot_mgmt_ctrl_tb: host and slot controller joined over one link, run over AHB-Lite
// assumes straps 3'h5, so the target answers at 7'h45
module hot_plug_slot_mgmt_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import hot_plug_pkg::*;
  localparam logic [6:0] DEV = {ADDR_PREFIX, 3'h5};
  logic clk, sys_rst, hsel, hwrite, hready, dHot, inUv, sbUv, attOe, nk;
  logic [1:0] htrans, mReq, aReq, ovrN, mGood, aGood, oc12, oc3, ocAux, hot, gin;
  logic [1:0] m12, m3, aux, pgOe, fOe;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [2:0] strap;
  logic [7:0] rx;
  int err_count, check_count;
  smbus_link_if link ();
  hot_plug_slot_dev hot_plug_slot_dev_i (.clk(clk), .sys_rst(sys_rst), .serialMgmtPort(link.dev),
    .mainPowerRequest(mReq), .auxPowerRequest(aReq), .overrideN(ovrN), .mainGood(mGood),
    .auxGood(aGood), .oc12Trip(oc12), .oc3Trip(oc3), .ocAuxTrip(ocAux), .slotHot(hot),
    .inputUv(inUv), .standbySupplyUv(sbUv), .dieHot(dHot), .generalInput(gin),
    .addrStrapBit2(strap[2]), .addrStrapBit1(strap[1]), .addrStrapBit0(strap[0]),
    .main12vOut(m12), .main3v3Out(m3), .auxSupplyOut(aux), .slotPowerGoodNIn(~pgOe),
    .slotPowerGoodNO(), .slotPowerGoodNOe(pgOe), .slotFaultNIn(~fOe), .slotFaultNO(),
    .slotFaultNOe(fOe), .attentionNIn(~attOe), .attentionNO(), .attentionNOe(attOe));
  smbus_host_ctrl #(.QUARTER_CYC(8)) smbus_host_ctrl_i (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(),
    .serialMgmtPort(link.host));
  hot_plug_slot_mgmt_ctrl_chk chk_i (.clk(clk), .sys_rst(sys_rst), .hostSclOe(link.hostSclOe),
    .hostSdaOe(link.hostSdaOe), .devSdaO(link.devSdaO), .devSdaOe(link.devSdaOe),
    .scl(link.scl), .sda(link.sda));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'h1);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'h1);
    rd = hrdata;
  endtask : ahb
  task automatic sm(input logic [1:0] op, input logic [7:0] cmd, input logic [7:0] dat,
    input logic [6:0] ad);
    ahb(HOST_CMD_ADDR, 1'h1, {1'h0, ad, 6'h00, op, dat, cmd});
    do ahb(HOST_STAT_ADDR, 1'h0, 32'h0); while (rd[HST_BUSY] !== 1'h0);
    rx = rd[15:8];
    nk = rd[HST_NACK];
  endtask : sm
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    sm(OP_WRITE, cmd, dat, DEV);
  endtask : wr
  task automatic rdb(input logic [7:0] cmd);
    sm(OP_READ, cmd, 8'h00, DEV);
  endtask : rdb
  task automatic t_ctrl;
    mGood <= 2'h3;
    aGood <= 2'h3;
    wt(8);
    chk("idle supplies", 8'h00, {m12, m3, aux, pgOe});
    wr(CMD_CTRL_A, 8'h03);
    chk("write ack", 8'h00, nk);
    chk("slot a on", 8'h07, {m12[0], m3[0], aux[0]});
    rdb(CMD_CTRL_A);
    chk("ctrl a", 8'hc3, rx);
    chk("power good", 8'h01, pgOe);
  endtask : t_ctrl
  task automatic t_fault;
    oc12 <= 2'h1;
    wt(8);
    chk("attention set", 8'h01, attOe);
    chk("fault pin", 8'h00, fOe);
    oc12 <= 2'h0;
    rdb(CMD_STAT_A);
    chk("stat a", 8'h04, rx & 8'h95);
    wr(CMD_STAT_A, 8'h04);
    rdb(CMD_STAT_A);
    chk("stat a cleared", 8'h00, rx & 8'h95);
    chk("attention cleared", 8'h00, attOe);
  endtask : t_fault
  task automatic t_mask;
    wr(CMD_COMMON, 8'h08);
    dHot <= 1'h1;
    wt(8);
    chk("masked attention", 8'h00, attOe);
    dHot <= 1'h0;
    rdb(CMD_COMMON);
    chk("common", 8'h2c, rx & 8'h3e);
    sm(OP_RECV, 8'h00, 8'h00, DEV);
    chk("receive", 8'h2c, rx & 8'h3e);
    wr(CMD_STAT_A, 8'h15);
    wr(CMD_COMMON, 8'h06);
    wt(4);
    chk("attention idle", 8'h00, attOe);
  endtask : t_mask
  task automatic t_addr;
    sm(OP_WRITE, CMD_CTRL_A, 8'h00, 7'h0c);
    chk("alert nack", 8'h01, nk);
    sm(OP_WRITE, CMD_CTRL_A, 8'h00, 7'h44);
    chk("other nack", 8'h01, nk);
    sm(OP_WRITE, 8'h08, 8'h00, DEV);
    chk("reserved refused", 8'h01, nk);
    wr(8'h01, 8'hff);
    chk("reserved ack", 8'h00, nk);
    wr(CMD_LIMIT, 8'hff);
    rdb(CMD_CTRL_A);
    chk("ctrl kept", 8'h03, rx & 8'h07);
    rdb(8'h01);
    chk("reserved read", 8'h00, rx);
  endtask : t_addr
  task automatic t_pin;
    wt(POWER_ON_DELAY_CYC);
    aReq <= 2'h2;
    wt(8);
    chk("pin aux on", 8'h01, aux[1]);
    ocAux <= 2'h2;
    wt(8);
    chk("fault pin set", 8'h02, fOe);
    ocAux <= 2'h0;
    wt(8);
    chk("fault pin held", 8'h02, fOe);
    rdb(CMD_STAT_B);
    chk("stat b fault", 8'h80, rx);
    aReq <= 2'h0;
    wt(8);
    chk("fault pin clear", 8'h00, fOe);
  endtask : t_pin
  task automatic t_ovr;
    wr(CMD_CTRL_A, 8'h00);
    wr(CMD_CTRL_A, 8'h07);
    ovrN <= 2'h0;
    wt(8);
    chk("pin ignored", 8'h01, pgOe[0]);
    chk("forced slot b", 8'h07, {m12[1], m3[1], aux[1]});
    chk("forced released", 8'h00, {pgOe[1], fOe[1]});
    inUv <= 1'h1;
    wt(8);
    chk("uv ignored", 8'h07, {m12[1], m3[1], aux[1]});
    sbUv <= 1'h1;
    wt(8);
    chk("standby uv", 8'h00, {m12[1], m3[1], aux[1]});
  endtask : t_ovr
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    sys_rst = 1'h1;
    {hsel, hwrite, dHot, inUv, sbUv} = 5'h00;
    {mReq, aReq, oc12, oc3, ocAux, hot, mGood, aGood} = 16'h0000;
    {htrans, haddr, hwdata} = 66'h0;
    ovrN = 2'h3;
    gin = 2'h2;
    strap = 3'h5;
    wt(10);
    sys_rst <= 1'h0;
    wt(4);
    t_ctrl;
    t_fault;
    t_mask;
    t_addr;
    t_pin;
    t_ovr;
    finish_test;
  end
  // the power-on wait dominates, the link traffic adds some 18k clocks
  initial begin
    wt(90000);
    err_count++;
    finish_test;
  end
endmodule : hot_plug_slot_mgmt_ctrl_tb
